// *** src/scs_pkg.sv ***
// Constants, command codes and helpers for the sensor command sequencer
package scs_pkg;

  // ----------------------------------------------------------------
  // Widths and layout
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned PIDX_W      = 5;
  localparam int unsigned PARAM_DEPTH = 32;
  localparam int unsigned DUE_W       = 6;
  localparam int unsigned RATE_W      = 8;

  // Parameter memory index of the channel enable list
  localparam logic [PIDX_W-1:0] PIDX_CHANNEL_LIST = 5'h01;
  // Reset value of every parameter memory location
  localparam logic [BYTE_W-1:0] PARAM_RST_VAL     = 8'h00;

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] NO_OPERATION_CMD     = 8'h00;
  localparam logic [BYTE_W-1:0] SOFT_RESET_CMD       = 8'h01;
  localparam logic [BYTE_W-1:0] BUS_ADDRESS_CHANGE_CMD = 8'h02;
  localparam logic [BYTE_W-1:0] PROXIMITY_SINGLE_SHOT_CMD = 8'h05;
  localparam logic [BYTE_W-1:0] AMBIENT_SINGLE_SHOT_CMD   = 8'h06;
  localparam logic [BYTE_W-1:0] BOTH_SINGLE_SHOT_CMD      = 8'h07;
  localparam logic [BYTE_W-1:0] PROXIMITY_LOOP_HALT_CMD   = 8'h09;
  localparam logic [BYTE_W-1:0] AMBIENT_LOOP_HALT_CMD     = 8'h0A;
  localparam logic [BYTE_W-1:0] BOTH_LOOP_HALT_CMD        = 8'h0B;
  localparam logic [BYTE_W-1:0] PROXIMITY_LOOP_RUN_CMD    = 8'h0D;
  localparam logic [BYTE_W-1:0] AMBIENT_LOOP_RUN_CMD      = 8'h0E;
  localparam logic [BYTE_W-1:0] BOTH_LOOP_RUN_CMD         = 8'h0F;

  // Parameter operations in command bits [6:5] when bit 7 is set
  localparam logic [1:0] OP_PARAM_READ  = 2'h0;
  localparam logic [1:0] OP_PARAM_WRITE = 2'h1;
  localparam logic [1:0] OP_PARAMETER_MASK_CLEAR_CMD   = 2'h2;
  localparam logic [1:0] OP_PARAMETER_MASK_SET_CMD    = 2'h3;

  // ----------------------------------------------------------------
  // Response codes
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RESP_RST_VAL      = 8'h00;
  localparam logic [BYTE_W-1:0] RESP_INVALID      = 8'h80;
  localparam logic [BYTE_W-1:0] RESP_OVERFLOW_BASE = 8'h88;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned WAKE_UNIT_NS     = 31250;
  localparam int unsigned WAKE_UNIT_CYCLES =
    (WAKE_UNIT_NS / CLK_PERIOD_NS) < 1 ? 1 : (WAKE_UNIT_NS / CLK_PERIOD_NS);
  localparam int unsigned UNIT_CNT_W       = 12;

  // ----------------------------------------------------------------
  // Sequencer states, Gray along sleep-exec-issue-wait
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    SCS_SLEEP = 2'b00,
    SCS_EXEC  = 2'b01,
    SCS_ISSUE = 2'b11,
    SCS_WAIT  = 2'b10
  } scs_state_type;

  // Lowest pending slot; proximity slots sit below ambient slots
  function automatic logic [2:0] scs_first_due(input logic [DUE_W-1:0] due);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = DUE_W - 1; i >= 0; i--)
    begin
      if (due[i])
      begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // Slot number to channel enable list bit position
  function automatic logic [2:0] scs_slot_channel(input logic [2:0] slot);
    return (slot < 3'h3) ? slot : 3'(slot + 3'h1);
  endfunction

endpackage

// *** src/scs_sequencer.sv ***
// Command interpreter and measurement scheduler of the light sensor
`timescale 1ns/10ps
module scs_sequencer
#(
  parameter int unsigned UNIT_CYCLES = scs_pkg::WAKE_UNIT_CYCLES
)
(
  input  wire logic                          core_clk,             // Clock, 50 MHz
  input  wire logic                          nrst,                 // Async reset, active low
  input  wire logic                          cmd_wr,               // Command register write
  input  wire logic [scs_pkg::BYTE_W-1:0]    cmd_byte,             // Written command byte
  input  wire logic [scs_pkg::BYTE_W-1:0]    param_write_mailbox,  // Host write mailbox
  input  wire logic [scs_pkg::RATE_W-1:0]    base_wake_interval,   // Wake units, 0 = forced
  input  wire logic [scs_pkg::RATE_W-1:0]    proximity_rate,       // Wakes per proximity run
  input  wire logic [scs_pkg::RATE_W-1:0]    ambient_rate,         // Wakes per ambient run
  input  wire logic                          meas_done,            // Conversion finished
  input  wire logic                          meas_overflow,        // Conversion overflowed
  output logic      [scs_pkg::BYTE_W-1:0]    param_read_mailbox,   // Host read mailbox
  output logic      [scs_pkg::BYTE_W-1:0]    response,             // Response register
  output logic                               meas_start,           // Start one conversion
  output logic      [2:0]                    meas_channel,         // Channel list bit number
  output logic                               seq_awake             // Sequencer out of sleep
);
  import scs_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  scs_state_type               state_r;
  logic                        cmd_pend_r;
  logic [BYTE_W-1:0]           cmd_r;
  logic [UNIT_CNT_W-1:0]       unit_cnt_r;
  logic [RATE_W-1:0]           ivl_cnt_r;
  logic                        wake_pend_r;
  logic                        ps_run_r;
  logic                        als_run_r;
  logic [RATE_W-1:0]           ps_cnt_r;
  logic [RATE_W-1:0]           als_cnt_r;
  logic [DUE_W-1:0]            due_r;
  logic                        force_r;
  logic [BYTE_W-1:0]           param_mem_r [PARAM_DEPTH];
  logic [BYTE_W-1:0]           response_r;
  logic [BYTE_W-1:0]           rd_mbox_r;
  logic                        meas_start_r;
  logic [2:0]                  meas_chan_r;

  logic                        take_cmd;
  logic                        take_wake;
  logic                        in_exec;
  logic                        soft_rst;
  logic                        is_param;
  logic [PIDX_W-1:0]           pidx;
  logic [BYTE_W-1:0]           pcur;
  logic [BYTE_W-1:0]           pnew;
  logic                        cmd_valid;
  logic [DUE_W-1:0]            chan_mask;
  logic [DUE_W-1:0]            force_due;
  logic                        is_force;
  logic                        ps_due;
  logic                        als_due;
  logic [DUE_W-1:0]            auto_due;
  logic [2:0]                  cur_slot;
  logic [DUE_W-1:0]            due_left;
  logic                        meas_end;
  logic                        pass_end;
  logic                        exec_done;
  logic                        ivl_hit;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  assign in_exec   = (state_r == SCS_EXEC);
  assign take_cmd  = (state_r == SCS_SLEEP) && cmd_pend_r;
  assign take_wake = (state_r == SCS_SLEEP) && !cmd_pend_r && wake_pend_r;
  assign soft_rst  = in_exec && (cmd_r == SOFT_RESET_CMD);
  assign is_param  = cmd_r[7];
  assign pidx      = cmd_r[PIDX_W-1:0];
  assign pcur      = param_mem_r[pidx];
  assign chan_mask = {param_mem_r[PIDX_CHANNEL_LIST][6:4],
                      param_mem_r[PIDX_CHANNEL_LIST][2:0]};

  always_comb
  begin
    unique case (cmd_r[6:5])
      OP_PARAM_READ:  pnew = pcur;
      OP_PARAM_WRITE: pnew = param_write_mailbox;
      OP_PARAMETER_MASK_CLEAR_CMD:   pnew = pcur & param_write_mailbox;
      OP_PARAMETER_MASK_SET_CMD:    pnew = pcur | param_write_mailbox;
    endcase
  end

  always_comb
  begin
    is_force  = 1'b0;
    force_due = '0;
    cmd_valid = 1'b1;
    if (!is_param)
    begin
      unique case (cmd_r)
        NO_OPERATION_CMD, SOFT_RESET_CMD, BUS_ADDRESS_CHANGE_CMD,
        PROXIMITY_LOOP_HALT_CMD, AMBIENT_LOOP_HALT_CMD, BOTH_LOOP_HALT_CMD,
        PROXIMITY_LOOP_RUN_CMD, AMBIENT_LOOP_RUN_CMD, BOTH_LOOP_RUN_CMD:
        begin
          cmd_valid = 1'b1;
        end
        PROXIMITY_SINGLE_SHOT_CMD, AMBIENT_SINGLE_SHOT_CMD, BOTH_SINGLE_SHOT_CMD:
        begin
          is_force  = 1'b1;
          force_due = chan_mask & {{3{cmd_r[1]}}, {3{cmd_r[0]}}};
        end
        default:
        begin
          cmd_valid = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Measurement selection
  // ----------------------------------------------------------------
  assign ps_due   = ps_run_r && (proximity_rate != '0) && (ps_cnt_r <= 8'h01);
  assign als_due  = als_run_r && (ambient_rate != '0) && (als_cnt_r <= 8'h01);
  assign auto_due = chan_mask & {{3{als_due}}, {3{ps_due}}};
  assign cur_slot = scs_first_due(due_r);
  assign due_left = due_r & ~(6'h01 << cur_slot);
  assign meas_end = (state_r == SCS_WAIT) && meas_done;
  assign pass_end = meas_end && (due_left == '0);
  assign exec_done = in_exec && cmd_valid && !soft_rst && (cmd_r != NO_OPERATION_CMD)
                     && !(is_force && (force_due != '0));

  // ----------------------------------------------------------------
  // Command latch; a command write is served ahead of a pending wake
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd_pend_r <= 1'b0;
      cmd_r      <= NO_OPERATION_CMD;
    end
    else if (cmd_wr)
    begin
      cmd_pend_r <= 1'b1;
      cmd_r      <= cmd_byte;
    end
    else if (take_cmd)
    begin
      cmd_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Base wake timer
  // ----------------------------------------------------------------
  assign ivl_hit = (unit_cnt_r == UNIT_CNT_W'(UNIT_CYCLES - 1))
                   && (ivl_cnt_r >= base_wake_interval - 8'h01);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      unit_cnt_r  <= '0;
      ivl_cnt_r   <= '0;
      wake_pend_r <= 1'b0;
    end
    else if (soft_rst || (base_wake_interval == '0))
    begin
      unit_cnt_r  <= '0;
      ivl_cnt_r   <= '0;
      wake_pend_r <= 1'b0;
    end
    else
    begin
      if (unit_cnt_r == UNIT_CNT_W'(UNIT_CYCLES - 1))
      begin
        unit_cnt_r <= '0;
        ivl_cnt_r  <= ivl_hit ? '0 : 8'(ivl_cnt_r + 8'h01);
      end
      else
      begin
        unit_cnt_r <= 12'(unit_cnt_r + 12'h001);
      end
      if (ivl_hit)
      begin
        wake_pend_r <= 1'b1;
      end
      else if (take_wake)
      begin
        wake_pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Autonomous loops and group counters
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ps_run_r  <= 1'b0;
      als_run_r <= 1'b0;
      ps_cnt_r  <= 8'h01;
      als_cnt_r <= 8'h01;
    end
    else if (soft_rst)
    begin
      ps_run_r  <= 1'b0;
      als_run_r <= 1'b0;
      ps_cnt_r  <= 8'h01;
      als_cnt_r <= 8'h01;
    end
    else if (in_exec && !is_param)
    begin
      if ((cmd_r == PROXIMITY_LOOP_RUN_CMD) || (cmd_r == BOTH_LOOP_RUN_CMD))
      begin
        ps_run_r <= 1'b1;
        ps_cnt_r <= 8'h01;
      end
      if ((cmd_r == AMBIENT_LOOP_RUN_CMD) || (cmd_r == BOTH_LOOP_RUN_CMD))
      begin
        als_run_r <= 1'b1;
        als_cnt_r <= 8'h01;
      end
      if ((cmd_r == PROXIMITY_LOOP_HALT_CMD) || (cmd_r == BOTH_LOOP_HALT_CMD))
      begin
        ps_run_r <= 1'b0;
      end
      if ((cmd_r == AMBIENT_LOOP_HALT_CMD) || (cmd_r == BOTH_LOOP_HALT_CMD))
      begin
        als_run_r <= 1'b0;
      end
    end
    else if (take_wake)
    begin
      if (ps_run_r && (proximity_rate != '0))
      begin
        ps_cnt_r <= ps_due ? proximity_rate : 8'(ps_cnt_r - 8'h01);
      end
      if (als_run_r && (ambient_rate != '0))
      begin
        als_cnt_r <= als_due ? ambient_rate : 8'(als_cnt_r - 8'h01);
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state machine
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r      <= SCS_SLEEP;
      due_r        <= '0;
      force_r      <= 1'b0;
      meas_start_r <= 1'b0;
      meas_chan_r  <= 3'h0;
    end
    else
    begin
      meas_start_r <= 1'b0;
      unique case (state_r)
        SCS_SLEEP:
        begin
          if (take_cmd)
          begin
            state_r <= SCS_EXEC;
          end
          else if (take_wake && (auto_due != '0))
          begin
            state_r <= SCS_ISSUE;
            due_r   <= auto_due;
            force_r <= 1'b0;
          end
        end
        SCS_EXEC:
        begin
          if (!soft_rst && is_force && (force_due != '0))
          begin
            state_r <= SCS_ISSUE;
            due_r   <= force_due;
            force_r <= 1'b1;
          end
          else
          begin
            state_r <= SCS_SLEEP;
          end
        end
        SCS_ISSUE:
        begin
          state_r      <= SCS_WAIT;
          meas_start_r <= 1'b1;
          meas_chan_r  <= scs_slot_channel(cur_slot);
        end
        SCS_WAIT:
        begin
          if (meas_done)
          begin
            due_r   <= due_left;
            state_r <= (due_left == '0) ? SCS_SLEEP : SCS_ISSUE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameter memory and read mailbox
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < PARAM_DEPTH; i++)
      begin
        param_mem_r[i] <= PARAM_RST_VAL;
      end
      rd_mbox_r <= PARAM_RST_VAL;
    end
    else if (soft_rst)
    begin
      for (int i = 0; i < PARAM_DEPTH; i++)
      begin
        param_mem_r[i] <= PARAM_RST_VAL;
      end
      rd_mbox_r <= PARAM_RST_VAL;
    end
    else if (in_exec && is_param)
    begin
      param_mem_r[pidx] <= pnew;
      rd_mbox_r         <= pnew;
    end
  end

  // ----------------------------------------------------------------
  // Response register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      response_r <= RESP_RST_VAL;
    end
    else if (soft_rst || (in_exec && (cmd_r == NO_OPERATION_CMD)))
    begin
      response_r <= RESP_RST_VAL;
    end
    else if (in_exec && !cmd_valid)
    begin
      response_r <= RESP_INVALID;
    end
    else if (meas_end && meas_overflow)
    begin
      response_r <= RESP_OVERFLOW_BASE | {5'h00, meas_chan_r};
    end
    else if ((exec_done || (pass_end && force_r)) && (response_r[7:4] == 4'h0))
    begin
      response_r <= {4'h0, 4'(response_r[3:0] + 4'h1)};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign param_read_mailbox = rd_mbox_r;
  assign response           = response_r;
  assign meas_start         = meas_start_r;
  assign meas_channel       = meas_chan_r;
  assign seq_awake          = (state_r != SCS_SLEEP);

endmodule

// *** tb/scs_checker_assertions.sv ***
// Port-level assertions for the sensor command sequencer
`timescale 1ns/10ps
module scs_checker
  import scs_pkg::*;
(
  input wire logic                       core_clk,           // Clock
  input wire logic                       nrst,               // Reset, active low
  input wire logic                       cmd_wr,             // Command write
  input wire logic [scs_pkg::BYTE_W-1:0] cmd_byte,           // Command byte
  input wire logic [scs_pkg::RATE_W-1:0] base_wake_interval, // Wake interval
  input wire logic                       meas_done,          // Conversion end
  input wire logic                       meas_overflow,      // Overflow flag
  input wire logic [scs_pkg::BYTE_W-1:0] response,           // Response
  input wire logic                       meas_start,         // Conversion start
  input wire logic [2:0]                 meas_channel,       // Channel
  input wire logic                       seq_awake           // Awake flag
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  logic [2:0] last_ch_r;
  logic       seen_r;
  // ----------------------------------------------------------------
  // Last channel started within the current pass
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      seen_r    <= 1'b0;
      last_ch_r <= 3'h0;
    end
    else if (!seq_awake || cmd_wr)
      seen_r <= 1'b0;
    else if (meas_start)
    begin
      seen_r    <= 1'b1;
      last_ch_r <= meas_channel;
    end
  end
  AST_PULSE: assert property (meas_start |=> !meas_start)
    else $error("start pulse longer than one cycle");
  AST_SLEEP: assert property (!seq_awake |-> !meas_start)
    else $error("conversion started while asleep");
  AST_ORDER: assert property (meas_start && seen_r |-> meas_channel > last_ch_r)
    else $error("channel order broken");
  AST_WAKE: assert property (cmd_wr && !seq_awake |-> ##[1:2] seq_awake)
    else $error("command did not wake sequencer");
  AST_NOP: assert property (cmd_wr && cmd_byte == NO_OPERATION_CMD && !seq_awake
    && base_wake_interval == 8'h00 |-> ##[1:3] response == RESP_RST_VAL)
    else $error("no-op did not clear response");
  AST_FORCED: assert property (base_wake_interval == 8'h00
    && $past(base_wake_interval) == 8'h00 && !seq_awake && !cmd_wr && !$past(cmd_wr)
    |=> !seq_awake)
    else $error("woke without command");
  AST_COUNT: assert property (response != $past(response) && response[7:4] == 4'h0
    && $past(response[7:4]) == 4'h0 && response != 8'h00
    |-> response[3:0] == $past(response[3:0]) + 4'h1)
    else $error("counter step wrong");
  AST_STICKY: assert property ($past(response[7:4]) != 4'h0
    |-> response[7:4] != 4'h0 || response == 8'h00)
    else $error("error code lost");
  AST_OVF: assert property (meas_done && meas_overflow && seen_r
    |=> response == (RESP_OVERFLOW_BASE | {5'h00, $past(meas_channel)}))
    else $error("overflow code wrong");
endmodule

// *** tb/scs_conv_model.sv ***
// Converter model answering conversion starts
`timescale 1ns/10ps
module scs_conv_model
(
  input wire logic       core_clk,      // Clock
  input wire logic       nrst,          // Reset, active low
  input wire logic       meas_start,    // Start pulse
  input wire logic [2:0] meas_channel,  // Channel
  input wire logic [2:0] ovf_ch,        // Channel that overflows
  input wire logic [2:0] lat,           // Conversion cycles, 1 to 7
  output logic           meas_done,     // Done pulse
  output logic           meas_overflow  // Overflow qualifier
);
  logic [2:0] cnt_r;
  logic [2:0] ch_r;
  logic       busy_r;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r        <= 1'b0;
      cnt_r         <= 3'h0;
      ch_r          <= 3'h0;
      meas_done     <= 1'b0;
      meas_overflow <= 1'b0;
    end
    else
    begin
      meas_done     <= 1'b0;
      // Meaningless outside done, so it toggles
      meas_overflow <= !meas_overflow;
      if (meas_start)
      begin
        busy_r <= 1'b1;
        cnt_r  <= lat;
        ch_r   <= meas_channel;
      end
      else if (busy_r && cnt_r <= 3'h1)
      begin
        busy_r        <= 1'b0;
        meas_done     <= 1'b1;
        meas_overflow <= (ch_r == ovf_ch);
      end
      else
        cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the sensor command sequencer
`timescale 1ns/10ps
module tb;
  import scs_pkg::*;
  logic       core_clk, nrst, cmd_wr, meas_done, meas_overflow, meas_start, seq_awake;
  logic [7:0] cmd_byte, param_write_mailbox, base_wake_interval, proximity_rate;
  logic [7:0] ambient_rate, param_read_mailbox, response, exp_resp, mb;
  logic [7:0] mem [32];
  logic [2:0] meas_channel, ovf_ch, lat;
  logic [23:0] seq;
  int         miscompares, check_count, cycles, seed, pc, ac, t0, t1;
  scs_sequencer #(.UNIT_CYCLES(4)) dut (.core_clk, .nrst, .cmd_wr, .cmd_byte,
    .param_write_mailbox, .base_wake_interval, .proximity_rate, .ambient_rate,
    .meas_done, .meas_overflow, .param_read_mailbox, .response, .meas_start,
    .meas_channel, .seq_awake);
  scs_conv_model conv (.core_clk, .nrst, .meas_start, .meas_channel, .ovf_ch, .lat,
    .meas_done, .meas_overflow);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (meas_start === 1'b1)
    begin
      seq = {seq[19:0], 1'b0, meas_channel};
      if (meas_channel === 3'h0)
      begin
        pc++;
        t0 = t1;
        t1 = cycles;
      end
      if (meas_channel === 3'h4)
        ac++;
    end
    if (cycles == 20000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] nr(input logic [7:0] r);
    return (r[7:4] != 4'h0) ? r : {4'h0, r[3:0] + 4'h1};
  endfunction
  function automatic logic [23:0] exp_seq(input logic [7:0] l, input logic [1:0] g);
    logic [23:0] s;
    s = 24'h00_0000;
    for (int i = 0; i < 7; i++)
      if (i != 3 && l[i] && g[i > 3])
        s = {s[19:0], 4'(i)};
    return s;
  endfunction
  task automatic do_cmd(input logic [7:0] c);
    int n, k;
    n = 0;
    k = 0;
    @(negedge core_clk);
    cmd_wr = 1'b1;
    cmd_byte = c;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    cmd_byte = 8'($random(seed));
    while (k < 3 && n < 400)
    begin
      @(negedge core_clk);
      n++;
      k = (seq_awake === 1'b0) ? k + 1 : 0;
    end
  endtask
  task automatic ccmd(input logic [7:0] c);
    do_cmd(c);
    exp_resp = nr(exp_resp);
    check(response, exp_resp);
  endtask
  task automatic pop(input logic [1:0] op, input logic [4:0] idx, input logic [7:0] v);
    param_write_mailbox = v;
    case (op)
      2'h0: mb = mem[idx];
      2'h1: mb = v;
      2'h2: mb = mem[idx] & v;
      default: mb = mem[idx] | v;
    endcase
    mem[idx] = mb;
    ccmd({1'b1, op, idx});
    check(param_read_mailbox, mb);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    seed = 15;
    core_clk = 0;
    nrst = 0;
    cmd_wr = 0;
    cmd_byte = 8'h00;
    param_write_mailbox = 8'h00;
    base_wake_interval = 8'h00;
    proximity_rate = 8'h01;
    ambient_rate = 8'h02;
    ovf_ch = 3'h7;
    lat = 3'h2;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    exp_resp = 8'h00;
    seq = 24'h00_0000;
    for (int i = 0; i < 32; i++)
      mem[i] = 8'h00;
    repeat (16) @(negedge core_clk);
    nrst = 1;
    for (int i = 0; i < 16; i++)
      pop(2'(i), 5'($random(seed)), 8'($random(seed)));
    $display("test parameter operations done");
    ccmd(BUS_ADDRESS_CHANGE_CMD);
    for (int i = 0; i < 5; i++)
    begin
      do_cmd((i == 4) ? {4'h1, 4'($random(seed))}
                      : 8'({8'h03, 8'h04, 8'h08, 8'h0C} >> (24 - 8 * i)));
      exp_resp = RESP_INVALID;
      check(response, exp_resp);
      pop(2'h1, 5'h02, 8'h3C);
      do_cmd(NO_OPERATION_CMD);
      exp_resp = 8'h00;
      check(response, exp_resp);
    end
    $display("test error codes done");
    for (int i = 0; i < 6; i++)
    begin
      lat = 3'(1 + ($random(seed) & 3));
      pop(2'h1, PIDX_CHANNEL_LIST, (i == 0) ? 8'h77 : 8'($random(seed)) & 8'h77);
      for (int c = 5; c < 8; c++)
      begin
        seq = 24'h00_0000;
        ccmd(8'(c));
        check(seq, exp_seq(mem[1], 2'(c)));
      end
    end
    pop(2'h3, PIDX_CHANNEL_LIST, 8'h77);
    ovf_ch = 3'h5;
    do_cmd(AMBIENT_SINGLE_SHOT_CMD);
    check(response, 8'h8D);
    do_cmd(NO_OPERATION_CMD);
    exp_resp = 8'h00;
    ovf_ch = 3'h7;
    $display("test single shots done");
    base_wake_interval = 8'd20;
    pc = 0;
    ac = 0;
    ccmd(BOTH_LOOP_RUN_CMD);
    repeat (600) @(negedge core_clk);
    ccmd(BOTH_LOOP_HALT_CMD);
    check(ac, (pc + 1) / 2);
    check(pc >= 6, 1);
    check(t1 - t0, 80);
    ccmd(BOTH_LOOP_RUN_CMD);
    ccmd(PROXIMITY_LOOP_HALT_CMD);
    pc = 0;
    ac = 0;
    repeat (400) @(negedge core_clk);
    ccmd(BOTH_LOOP_HALT_CMD);
    check(pc, 0);
    check(ac >= 2, 1);
    proximity_rate = 8'h00;
    ambient_rate = 8'h00;
    ccmd(PROXIMITY_LOOP_RUN_CMD);
    ccmd(AMBIENT_LOOP_RUN_CMD);
    pc = 0;
    ac = 0;
    repeat (400) @(negedge core_clk);
    ccmd(AMBIENT_LOOP_HALT_CMD);
    ccmd(BOTH_LOOP_HALT_CMD);
    check(pc + ac, 0);
    $display("test autonomous loops done");
    base_wake_interval = 8'h00;
    do_cmd(SOFT_RESET_CMD);
    exp_resp = 8'h00;
    check(response, exp_resp);
    mem[1] = 8'h00;
    pop(2'h0, PIDX_CHANNEL_LIST, 8'h55);
    pop(2'h1, PIDX_CHANNEL_LIST, 8'h77);
    proximity_rate = 8'h01;
    ccmd(BOTH_LOOP_RUN_CMD);
    pc = 0;
    ac = 0;
    for (int i = 0; i < 300; i++)
    begin
      @(negedge core_clk);
      param_write_mailbox = 8'($random(seed));
      ambient_rate = 8'($random(seed));
      if (seq_awake !== 1'b0)
        pc++;
    end
    check(pc + ac, 0);
    $display("test soft reset done");
    report_and_stop();
  end
endmodule
bind scs_sequencer scs_checker chk (.core_clk, .nrst, .cmd_wr, .cmd_byte,
  .base_wake_interval, .meas_done, .meas_overflow, .response, .meas_start,
  .meas_channel, .seq_awake);
